//--- hw/parallel_printer_port.sv
// Printer-side logic of the 8-bit host parallel port
//
// Added by the designer: the register offsets and the strobed register port.
`default_nettype none

// Summary of operation
// - The host drives the data byte and pulses strobe; the printer samples the byte on strobe.
// - Acknowledge is pulsed once a byte has been taken in and stored.
// - Busy is held while print data is processed or an alarm exists.
// - Fault is asserted when paper is out or an alarm is present.
// - Compatibility, nibble and ECP modes exist, ECP can be switched off, compatibility moves 8 bits.
// - Every received byte goes into a receive buffer whose capacity is one of three settings.
// - Handshake and busy run in every mode; with end release the host never overruns the buffer, with centre release busy drops mid-ack even when full.
// - The acknowledge pulse is narrow, medium or wide, narrow by default.
// - Busy drops at the end of acknowledge by default, or at its centre when chosen.
// - Input prime is ignored by default, or initializes after a low pulse of at least 3 or 50 us.
// - Unidirectional setting keeps the data lines undriven; bidirectional is the default.
// - Reception while offline is a setting, off by default.
// - Settings are held across power cycles.
module parallel_printer_port
   import pport_pkg::*;
(
   // Clock and reset
   input  wire logic        CLK,
   input  wire logic        RST,
   // Register port
   input  wire logic [7:0]  ADDR,
   input  wire logic [31:0] WDATA,
   input  wire logic        WR,
   input  wire logic        RD,
   output logic      [31:0] RDATA,
   // Stored settings from non-volatile memory, loaded after reset
   input  wire logic [12:0] NV_CFG,
   output logic      [12:0] NV_CFG_OUT,
   output logic             NV_SAVE,
   // Host pins, active low where the name says so
   input  wire logic [7:0]  PD_I,
   output logic      [7:0]  PD_O,
   output logic             PD_OE,
   input  wire logic        STROBE_N,
   input  wire logic        AUTOFD_N,
   input  wire logic        SELIN_N,
   input  wire logic        INIT_N,
   output logic             ACK_N,
   output logic             BUSY,
   output logic             PERROR,
   output logic             SELECT,
   output logic             FAULT_N,
   // Interrupt and initialization
   output logic             IRQ,
   output logic             PRIME_PULSE
);

   function automatic logic [4:0] buf_limit(input logic [1:0] sz);
      if (sz == 2'h0) return BUF_LIM_SMALL;
      else if (sz == 2'h1) return BUF_LIM_MID;
      else return BUF_LIM_FULL;
   endfunction

   function automatic logic [9:0] ack_cycles(input ack_width_t w);
      if (w == ACKW_MEDIUM) return ACK_MEDIUM_CYC;
      else if (w == ACKW_WIDE) return ACK_WIDE_CYC;
      else return ACK_NARROW_CYC;
   endfunction

   cfg_t        cfg_q;
   logic        loaded_q;
   logic [4:0]  ctrl_q;
   logic [IRQ_W-1:0] ist_q;
   logic [IRQ_W-1:0] ien_q;
   logic [7:0]  txd_q;
   logic [2:0]  stb_s_q;
   logic [2:0]  init_s_q;
   logic [2:0]  afd_s_q;
   logic [2:0]  sel_s_q;
   logic [7:0]  pd_s1_q;
   logic [7:0]  pd_s2_q;
   logic        stb_q;
   logic        init_q;
   logic [1:0]  req_q;
   logic [7:0]  byte_q;
   hs_state_t   hs_q;
   logic [9:0]  cnt_q;
   logic [9:0]  prime_cnt_q;
   logic [7:0]  mem_q [BUF_DEPTH];
   logic [BUF_AW-1:0] wp_q;
   logic [BUF_AW-1:0] rp_q;
   logic [4:0]  lvl_q;
   reg_req_t    req;

   logic        online;
   logic        alarm;
   logic        accept;
   logic        stb_fall;
   logic        push;
   logic        pop;
   logic        full;
   logic        prime_hit;
   logic [IRQ_W-1:0] ev;
   logic [9:0]  ack_len;

   assign req      = '{addr: ADDR, wdata: WDATA, wr: WR, rd: RD};
   assign online   = ctrl_q[CTRL_ONLINE_BIT];
   assign alarm    = ctrl_q[CTRL_ALARM_BIT];
   assign ack_len  = ack_cycles(cfg_q.ackw);
   assign full     = (lvl_q >= buf_limit(cfg_q.bufsz));
   // Strobe counts once two later stages agree, filtering glitches
   assign stb_fall = stb_q && !stb_s_q[1] && !stb_s_q[2];
   assign accept   = cfg_q.enable && (online || cfg_q.offline_rx);
   assign push     = (hs_q == HS_STORE) && !full;
   assign pop      = req.rd && (req.addr == RXDATA_ADDR) && (lvl_q != 5'd0);
   assign prime_hit = (cfg_q.prime == PRIME_3US) ? (prime_cnt_q == PRIME_SHORT_CYC)
                    : (cfg_q.prime == PRIME_50US) ? (prime_cnt_q == PRIME_LONG_CYC)
                    : 1'b0;
   assign ev = {stb_fall && full,
                (afd_s_q[1] == afd_s_q[2] && sel_s_q[1] == sel_s_q[2] &&
                 req_q != {afd_s_q[2], sel_s_q[2]}), prime_hit, push};

   // Pin synchronisers, three stages for each control line, two for the data bus
   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         stb_s_q  <= 3'h7;
         init_s_q <= 3'h7;
         afd_s_q  <= 3'h7;
         sel_s_q  <= 3'h7;
         pd_s1_q  <= 8'h00;
         pd_s2_q  <= 8'h00;
         stb_q    <= 1'b1;
         init_q   <= 1'b1;
         req_q    <= 2'h3;
      end else begin
         stb_s_q  <= {stb_s_q[1:0], STROBE_N};
         init_s_q <= {init_s_q[1:0], INIT_N};
         afd_s_q  <= {afd_s_q[1:0], AUTOFD_N};
         sel_s_q  <= {sel_s_q[1:0], SELIN_N};
         pd_s1_q  <= PD_I;
         pd_s2_q  <= pd_s1_q;
         if (stb_s_q[1] == stb_s_q[2]) stb_q <= stb_s_q[2];
         if (init_s_q[1] == init_s_q[2]) init_q <= init_s_q[2];
         if (afd_s_q[1] == afd_s_q[2] && sel_s_q[1] == sel_s_q[2]) begin
            req_q <= {afd_s_q[2], sel_s_q[2]};
         end
      end
   end

   // Settings: loaded from non-volatile store after reset, saved on write
   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         cfg_q      <= cfg_t'(CFG_RESET);
         loaded_q   <= 1'b0;
         NV_SAVE    <= 1'b0;
         NV_CFG_OUT <= CFG_RESET;
      end else begin
         NV_SAVE <= 1'b0;
         if (!loaded_q) begin
            cfg_q    <= cfg_t'(NV_CFG);
            loaded_q <= 1'b1;
         end else if (req.wr && req.addr == CFG_ADDR) begin
            cfg_q      <= cfg_t'(req.wdata[12:0]);
            NV_CFG_OUT <= req.wdata[12:0];
            NV_SAVE    <= 1'b1;
            // ECP disabled falls back to compatibility
            if (!req.wdata[CFG_ECP_BIT] && req.wdata[CFG_MODE_LSB+1 -: 2] == MODE_ECP) begin
               cfg_q.mode <= MODE_COMPAT;
            end
         end
      end
   end

   // Control, interrupt enable and reverse data registers
   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         ctrl_q <= 5'h00;
         ien_q  <= '0;
         txd_q  <= 8'h00;
      end else if (req.wr) begin
         if (req.addr == CTRL_ADDR) ctrl_q <= req.wdata[4:0];
         else if (req.addr == IRQ_EN_ADDR) ien_q <= req.wdata[IRQ_W-1:0];
         else if (req.addr == TXDATA_ADDR) txd_q <= req.wdata[7:0];
      end
   end

   // Sticky status: a new event beats a clear in the same cycle
   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         ist_q <= '0;
      end else begin
         ist_q <= (ist_q & ~((req.wr && req.addr == IRQ_CL_ADDR) ?
                  req.wdata[IRQ_W-1:0] : '0)) | ev;
      end
   end

   // Handshake: capture, store, then acknowledge
   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         hs_q   <= HS_IDLE;
         cnt_q  <= 10'h000;
         byte_q <= 8'h00;
      end else begin
         case (hs_q)
            HS_IDLE: begin
               if (stb_fall && accept && !full) begin
                  byte_q <= pd_s2_q;
                  hs_q   <= HS_STORE;
               end
            end
            HS_STORE: begin
               if (!full) begin
                  hs_q  <= HS_ACK;
                  cnt_q <= 10'h000;
               end
            end
            HS_ACK: begin
               if (cnt_q == ack_len - 10'h001) hs_q <= HS_IDLE;
               else cnt_q <= cnt_q + 10'h001;
            end
            default: hs_q <= HS_IDLE;
         endcase
      end
   end

   // Receive buffer
   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         wp_q  <= '0;
         rp_q  <= '0;
         lvl_q <= 5'h00;
      end else begin
         if (push) begin
            mem_q[wp_q] <= byte_q;
            wp_q        <= wp_q + 1'b1;
         end
         if (pop) rp_q <= rp_q + 1'b1;
         lvl_q <= lvl_q + 5'(push) - 5'(pop);
      end
   end

   // Prime pulse width counter
   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         prime_cnt_q <= 10'h000;
         PRIME_PULSE <= 1'b0;
      end else begin
         PRIME_PULSE <= prime_hit;
         if (init_q || cfg_q.prime == PRIME_OFF) prime_cnt_q <= 10'h000;
         // Runs one past the long minimum so a held line hits only once
         else if (prime_cnt_q <= PRIME_LONG_CYC) prime_cnt_q <= prime_cnt_q + 10'h001;
      end
   end

   // Host-facing outputs, all registered
   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         ACK_N   <= 1'b1;
         BUSY    <= 1'b1;
         PERROR  <= 1'b0;
         SELECT  <= 1'b0;
         FAULT_N <= 1'b1;
         PD_O    <= 8'h00;
         PD_OE   <= 1'b0;
         IRQ     <= 1'b0;
      end else begin
         ACK_N <= !(hs_q == HS_ACK);
         // Busy from capture to end of ack (or its centre), while idle and full or not accepting, during processing or alarm
         BUSY <= stb_fall || hs_q == HS_STORE ||
                 (hs_q == HS_ACK && (!cfg_q.centre ||
                   cnt_q < (ack_len >> 1))) ||
                 (hs_q == HS_IDLE && (full || !accept)) ||
                 ctrl_q[CTRL_PROC_BIT] || alarm;
         PERROR  <= !ctrl_q[CTRL_PAPER_BIT];
         SELECT  <= online;
         FAULT_N <= !(!ctrl_q[CTRL_PAPER_BIT] || alarm);
         PD_O    <= txd_q;
         // Unidirectional setting never drives the lines
         PD_OE   <= cfg_q.bidir && ctrl_q[CTRL_TXEN_BIT];
         IRQ     <= |(ist_q & ien_q);
      end
   end

   // Read data, one cycle after the strobe; unmapped reads zero
   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         RDATA <= 32'h0000_0000;
      end else if (req.rd) begin
         if (req.addr == CFG_ADDR) RDATA <= {19'h0, cfg_q};
         else if (req.addr == CTRL_ADDR) RDATA <= {27'h0, ctrl_q};
         else if (req.addr == STAT_ADDR) RDATA <= {22'h0, req_q, hs_q, init_q, full,
                                                   BUSY, ACK_N, 2'h0};
         else if (req.addr == IRQ_ST_ADDR) RDATA <= {28'h0, ist_q};
         else if (req.addr == IRQ_EN_ADDR) RDATA <= {28'h0, ien_q};
         else if (req.addr == RXDATA_ADDR) RDATA <= {24'h0, mem_q[rp_q]};
         else if (req.addr == LEVEL_ADDR) RDATA <= {27'h0, lvl_q};
         else RDATA <= 32'h0000_0000;
      end else begin
         RDATA <= 32'h0000_0000;
      end
   end

endmodule // parallel_printer_port
`default_nettype wire

//--- shared/pport_pkg.sv
// Package: constants, types and register map of the printer-side parallel port
`default_nettype none
package pport_pkg;

   // Register offsets, byte addresses on the plain register port
   localparam logic [7:0] CFG_ADDR    = 8'h00;
   localparam logic [7:0] CTRL_ADDR   = 8'h04;
   localparam logic [7:0] STAT_ADDR   = 8'h08;
   localparam logic [7:0] IRQ_ST_ADDR = 8'h0c;
   localparam logic [7:0] IRQ_EN_ADDR = 8'h10;
   localparam logic [7:0] IRQ_CL_ADDR = 8'h14;
   localparam logic [7:0] RXDATA_ADDR = 8'h18;
   localparam logic [7:0] TXDATA_ADDR = 8'h1c;
   localparam logic [7:0] LEVEL_ADDR  = 8'h20;

   // Configuration field positions
   localparam int CFG_BIDIR_BIT   = 0;
   localparam int CFG_ECP_BIT     = 1;
   localparam int CFG_ACKW_LSB    = 2;
   localparam int CFG_CENTRE_BIT  = 4;
   localparam int CFG_PRIME_LSB   = 5;
   localparam int CFG_OFFRX_BIT   = 7;
   localparam int CFG_BUFSZ_LSB   = 8;
   localparam int CFG_MODE_LSB    = 10;
   localparam int CFG_ENABLE_BIT  = 12;

   // Control bits
   localparam int CTRL_ONLINE_BIT = 0;
   localparam int CTRL_PAPER_BIT  = 1;
   localparam int CTRL_ALARM_BIT  = 2;
   localparam int CTRL_PROC_BIT   = 3;
   localparam int CTRL_TXEN_BIT   = 4;

   // Interrupt bits
   localparam int IRQ_RX_BIT      = 0;
   localparam int IRQ_PRIME_BIT   = 1;
   localparam int IRQ_MODE_BIT    = 2;
   localparam int IRQ_OVF_BIT     = 3;
   localparam int IRQ_W           = 4;

   // Defaults: bidirectional, ECP on, narrow ack, end release, prime off
   localparam logic [12:0] CFG_RESET = 13'h1003;

   // Ack widths and prime minima
   localparam int CLK_MHZ         = 10;
   localparam int ACK_NARROW_NS   = 500;
   localparam int ACK_MEDIUM_NS   = 1000;
   localparam int ACK_WIDE_NS     = 3000;
   localparam int PRIME_SHORT_US  = 3;
   localparam int PRIME_LONG_US   = 50;
   localparam logic [9:0] ACK_NARROW_CYC =
      10'((ACK_NARROW_NS * CLK_MHZ + 999) / 1000);
   localparam logic [9:0] ACK_MEDIUM_CYC =
      10'((ACK_MEDIUM_NS * CLK_MHZ + 999) / 1000);
   localparam logic [9:0] ACK_WIDE_CYC =
      10'((ACK_WIDE_NS * CLK_MHZ + 999) / 1000);
   localparam logic [9:0] PRIME_SHORT_CYC = 10'(PRIME_SHORT_US * CLK_MHZ);
   localparam logic [9:0] PRIME_LONG_CYC  = 10'(PRIME_LONG_US * CLK_MHZ);

   // Receive buffer depth in bytes, stand-ins for the three capacities
   localparam int BUF_DEPTH       = 16;
   localparam int BUF_AW          = 4;
   localparam logic [4:0] BUF_LIM_SMALL = 5'd4;
   localparam logic [4:0] BUF_LIM_MID   = 5'd8;
   localparam logic [4:0] BUF_LIM_FULL  = 5'd16;

   typedef enum logic [1:0] {
      ACKW_NARROW = 2'h0, ACKW_MEDIUM = 2'h1, ACKW_WIDE = 2'h2
   } ack_width_t;
   typedef enum logic [1:0] {
      PRIME_OFF = 2'h0, PRIME_3US = 2'h1, PRIME_50US = 2'h2
   } prime_sel_t;
   typedef enum logic [1:0] {
      MODE_COMPAT = 2'h0, MODE_NIBBLE = 2'h1, MODE_ECP = 2'h2
   } xfer_mode_t;
   typedef enum logic [1:0] {
      HS_IDLE = 2'b00, HS_STORE = 2'b01, HS_ACK = 2'b11
   } hs_state_t;

   typedef struct packed {
      logic       enable;
      xfer_mode_t mode;
      logic [1:0] bufsz;
      logic       offline_rx;
      prime_sel_t prime;
      logic       centre;
      ack_width_t ackw;
      logic       ecp_en;
      logic       bidir;
   } cfg_t;

   typedef struct packed {
      logic [7:0] addr;
      logic [31:0] wdata;
      logic       wr;
      logic       rd;
   } reg_req_t;

endpackage : pport_pkg
`default_nettype wire

//--- verification/pport_chk_sva.sv
// Checker: port-level handshake, status, prime and register assertions for the parallel port
`default_nettype none
module pport_chk
   import pport_pkg::*;
(
   // Clock, reset and register port
   input wire logic        CLK,
   input wire logic        RST,
   input wire logic [7:0]  ADDR,
   input wire logic        WR,
   input wire logic        RD,
   input wire logic [31:0] RDATA,
   input wire logic        NV_SAVE,
   // Host pins
   input wire logic        STROBE_N,
   input wire logic        INIT_N,
   input wire logic        ACK_N,
   input wire logic        BUSY,
   input wire logic        PERROR,
   input wire logic        SELECT,
   input wire logic        FAULT_N,
   input wire logic        PRIME_PULSE
);
   default clocking @(posedge CLK); endclocking
   default disable iff (RST);
   // Narrow pulse is the floor, wide pulse the ceiling
   sequence s_ack_pulse;
      !ACK_N [*5] ##[1:26] ACK_N;
   endsequence
   property p_ack_width;
      $fell(ACK_N) |-> s_ack_pulse;
   endproperty
   property p_ack_in_busy;
      $fell(ACK_N) |-> BUSY && $past(BUSY, 2);
   endproperty
   // Sync stages add a few cycles before capture
   property p_busy_take;
      $fell(STROBE_N) && !BUSY && ACK_N && SELECT |-> ##[1:8] BUSY;
   endproperty
   property p_busy_hold;
      $rose(BUSY) |-> BUSY [*3];
   endproperty
   property p_nv_save;
      WR && ADDR == CFG_ADDR |=> NV_SAVE;
   endproperty
   property p_rdata_idle;
      !$past(RD) |-> RDATA == 32'h0;
   endproperty
   property p_fault;
      PERROR |-> ##[0:1] !FAULT_N;
   endproperty
   property p_prime;
      PRIME_PULSE |-> !$past(INIT_N, 30) ##1 !PRIME_PULSE;
   endproperty
   a_ack_width: assert property (p_ack_width) else $error("ack pulse width");
   a_ack_in_busy: assert property (p_ack_in_busy) else $error("ack outside busy");
   a_busy_take: assert property (p_busy_take) else $error("no busy on strobe");
   a_busy_hold: assert property (p_busy_hold) else $error("busy too short");
   a_nv_save: assert property (p_nv_save) else $error("settings not saved");
   a_rdata_idle: assert property (p_rdata_idle) else $error("read data off cycle");
   a_fault: assert property (p_fault) else $error("fault missing");
   a_prime: assert property (p_prime) else $error("prime too early");
endmodule // pport_chk

bind parallel_printer_port pport_chk chk (
   .CLK, .RST, .ADDR, .WR, .RD, .RDATA, .NV_SAVE, .STROBE_N, .INIT_N,
   .ACK_N, .BUSY, .PERROR, .SELECT, .FAULT_N, .PRIME_PULSE
);
`default_nettype wire

//--- verification/host_model.sv
// Host-side model driving strobe, data and control lines
`default_nettype none
module host_model (
   // Clock and printer status
   input  wire logic       CLK,
   input  wire logic       BUSY,
   input  wire logic       ACK_N,
   // Host-driven lines
   output logic      [7:0] PD,
   output logic            STROBE_N,
   output logic            INIT_N,
   output logic            AUTOFD_N,
   output logic            SELIN_N
);
   timeunit 1ns;
   timeprecision 1ns;
   initial begin
      PD = 8'h00;
      STROBE_N = 1'b1;
      INIT_N = 1'b1;
      AUTOFD_N = 1'b1;
      SELIN_N = 1'b1;
   end
   // Waits for ack too, so centre release never overlaps the pulse
   task automatic send(input logic [7:0] b, input logic hold);
      int n;
      n = 0;
      while (hold && (BUSY !== 1'b0 || ACK_N !== 1'b1) && n < 200) begin
         @(posedge CLK);
         n++;
      end
      @(posedge CLK);
      PD <= b;
      repeat (2) @(posedge CLK);
      STROBE_N <= 1'b0;
      repeat (6) @(posedge CLK);
      STROBE_N <= 1'b1;
      repeat (2) @(posedge CLK);
      PD <= ~b;
   endtask
   task automatic prime(input int n);
      @(posedge CLK);
      INIT_N <= 1'b0;
      repeat (n) @(posedge CLK);
      INIT_N <= 1'b1;
      repeat (5) @(posedge CLK);
   endtask
   task automatic mode_req(input logic v);
      @(posedge CLK);
      AUTOFD_N <= v;
      SELIN_N <= ~v;
   endtask
endmodule // host_model
`default_nettype wire

//--- verification/parallel_printer_port_bench.sv
// Testbench: register tasks and host handshake scenarios
`default_nettype none
module parallel_printer_port_bench import pport_pkg::*;;
   timeunit 1ns;
   timeprecision 1ns;
   logic        CLK, PD_OE, STROBE_N, AUTOFD_N, SELIN_N, INIT_N, ACK_N, BUSY;
   logic        PERROR, SELECT, FAULT_N, IRQ, PRIME_PULSE;
   logic        RST = 1'b1, WR = 1'b0, RD = 1'b0, mid = 1'b0;
   logic [7:0]  ADDR = 8'h00, PD_O, host_pd;
   wire  [7:0]  PD_I;
   logic [31:0] WDATA = 32'h0, RDATA;
   logic [12:0] nv_out;
   logic [9:0]  ackc [3] = '{ACK_NARROW_CYC, ACK_MEDIUM_CYC, ACK_WIDE_CYC};
   int          lim [3] = '{30, int'(PRIME_SHORT_CYC), int'(PRIME_LONG_CYC)};
   int          errors = 0, checks = 0, lo = 0, last_ack = 0, pulses = 0;
   assign PD_I = PD_OE ? PD_O : host_pd;
   parallel_printer_port uut (
      .CLK, .RST, .ADDR, .WDATA, .WR, .RD, .RDATA, .NV_CFG(13'h1001), .NV_CFG_OUT(nv_out),
      .NV_SAVE(), .PD_I, .PD_O, .PD_OE, .STROBE_N, .AUTOFD_N, .SELIN_N, .INIT_N,
      .ACK_N, .BUSY, .PERROR, .SELECT, .FAULT_N, .IRQ, .PRIME_PULSE
   );
   host_model host (
      .CLK, .BUSY, .ACK_N, .PD(host_pd), .STROBE_N, .INIT_N, .AUTOFD_N, .SELIN_N
   );
   initial begin
      CLK = 1'b0;
      forever #50 CLK = ~CLK;
   end
   always @(posedge CLK) begin
      if (!ACK_N) begin
         lo <= lo + 1;
         if (!BUSY) mid <= 1'b1;
      end else if (lo != 0) begin
         last_ack <= lo;
         lo <= 0;
      end
      if (PRIME_PULSE === 1'b1) pulses <= pulses + 1;
   end
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      checks++;
      if (g !== e) begin
         errors++;
         $display("CHECK FAILED %0t got %h expected %h", $time, g, e);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge CLK);
      ADDR <= a;
      WDATA <= d;
      WR <= 1'b1;
      @(posedge CLK);
      WR <= 1'b0;
   endtask
   task automatic rc(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
      @(posedge CLK);
      ADDR <= a;
      RD <= 1'b1;
      @(posedge CLK);
      RD <= 1'b0;
      #1 chk(RDATA & m, e);
   endtask
   task automatic settle();
      int n;
      n = 0;
      while ((BUSY !== 1'b0 || ACK_N !== 1'b1) && n < 200) begin
         @(posedge CLK);
         n++;
      end
      chk(32'(n < 200), 32'h1);
      repeat (2) @(posedge CLK);
   endtask
   function automatic logic [31:0] cf(logic [1:0] w, logic c, logic [1:0] p, logic o,
                                      logic [1:0] s, logic bi);
      return {19'h0, 1'b1, 2'h0, s, o, p, c, w, 1'b0, bi};
   endfunction
   task automatic conclude();
      $display("checks %0d errors %0d", checks, errors);
      if (errors == 0 && checks > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   // Whole run needs well under this span
   initial begin
      repeat (20000) @(posedge CLK);
      errors++;
      conclude();
   end
   initial begin
      repeat (16) @(posedge CLK);
      chk({ACK_N, BUSY, PD_OE, IRQ}, 32'hc);
      RST <= 1'b0;
      repeat (2) @(posedge CLK);
      rc(CFG_ADDR, 32'h1001, '1);
      wr(CTRL_ADDR, 32'h3);
      repeat (3) @(posedge CLK);
      chk({SELECT, PERROR, FAULT_N, BUSY}, 32'ha);
      wr(CTRL_ADDR, 32'h1);
      repeat (3) @(posedge CLK);
      chk({SELECT, PERROR, FAULT_N}, 32'h6);
      wr(CTRL_ADDR, 32'h7);
      repeat (3) @(posedge CLK);
      chk({BUSY, FAULT_N}, 32'h2);
      wr(CTRL_ADDR, 32'h3);
      // Every width in both release modes, one transfer mode per pass
      for (int i = 0; i < 6; i++) begin
         WDATA = cf(2'(i % 3), 1'(i / 3), 2'h0, 1'b0, 2'h2, 1'b1) | 32'h2
                 | (32'(i % 3) << CFG_MODE_LSB);
         wr(CFG_ADDR, WDATA);
         rc(CFG_ADDR, WDATA, '1);
         chk(32'(nv_out), WDATA);
         mid = 1'b0;
         host.send(8'h30 + 8'(i), 1'b1);
         settle();
         chk(last_ack, 32'(ackc[i % 3]));
         chk(32'(mid), 32'(i / 3));
         rc(RXDATA_ADDR, 32'h30 + i, '1);
      end
      wr(TXDATA_ADDR, 32'ha5);
      for (int b = 0; b < 2; b++) begin
         wr(CFG_ADDR, cf(2'h0, 1'b0, 2'h0, 1'b0, 2'h2, 1'(b)));
         wr(CTRL_ADDR, 32'h13);
         repeat (3) @(posedge CLK);
         chk(PD_OE, 32'(b));
      end
      chk(PD_O, 32'ha5);
      wr(CTRL_ADDR, 32'h2);
      host.send(8'h77, 1'b0);
      repeat (10) @(posedge CLK);
      rc(LEVEL_ADDR, 32'h0, '1);
      wr(CFG_ADDR, cf(2'h0, 1'b0, 2'h0, 1'b1, 2'h2, 1'b1));
      host.send(8'h78, 1'b1);
      settle();
      rc(RXDATA_ADDR, 32'h78, '1);
      wr(CTRL_ADDR, 32'h3);
      wr(CFG_ADDR, cf(2'h0, 1'b0, 2'h0, 1'b0, 2'h0, 1'b1));
      wr(IRQ_CL_ADDR, 32'hf);
      for (int k = 0; k < 5; k++) host.send(8'(k), 1'(k < 4));
      repeat (20) @(posedge CLK);
      chk(BUSY, 32'h1);
      rc(LEVEL_ADDR, 32'h4, '1);
      rc(IRQ_ST_ADDR, 32'h9, 32'h9);
      wr(IRQ_EN_ADDR, 32'h8);
      repeat (2) @(posedge CLK);
      chk(IRQ, 32'h1);
      wr(IRQ_CL_ADDR, 32'h8);
      repeat (2) @(posedge CLK);
      chk(IRQ, 32'h0);
      for (int k = 0; k < 4; k++) rc(RXDATA_ADDR, 32'(k), '1);
      rc(LEVEL_ADDR, 32'h0, '1);
      // Just under and just over each minimum, ignored when off
      for (int p = 0; p < 3; p++) begin
         wr(CFG_ADDR, cf(2'h0, 1'b0, 2'(p), 1'b0, 2'h2, 1'b1));
         pulses = 0;
         host.prime(lim[p] - 10);
         host.prime(lim[p] + 10);
         repeat (10) @(posedge CLK);
         chk(pulses, 32'(p != 0));
      end
      wr(IRQ_CL_ADDR, 32'hf);
      host.mode_req(1'b0);
      repeat (10) @(posedge CLK);
      rc(IRQ_ST_ADDR, 32'h4, 32'h4);
      rc(8'h3c, 32'h0, '1);
      conclude();
   end
endmodule // parallel_printer_port_bench
`default_nettype wire
